// *** core/mstf_defines.svh ***
// Purpose: Register offsets, field positions, reset values and timing
//          constants of the monitor status-flag block
// Assumes: Included by bare name from the package and the top module
// Notes:   Definitions only
`ifndef MSTF_DEFINES_SVH
`define MSTF_DEFINES_SVH

// ==========================================================
// Register offsets (pointer values on the serial bus)
`define MSTF_OFS_CFG1 8'h00
`define MSTF_OFS_CFG2 8'h01
`define MSTF_OFS_STAT 8'h02
`define MSTF_OFS_ALRT 8'h03

// ==========================================================
// Reset values and write masks
`define MSTF_RST_CFG1 16'h399F
`define MSTF_RST_CFG2 16'hFF80
`define MSTF_RST_STAT 16'h0000
`define MSTF_RST_ALRT 16'h0000
`define MSTF_CFG1_WMASK 16'h3FFF
`define MSTF_CFG2_WMASK 16'hFF83

// ==========================================================
// Field positions
`define MSTF_B_SOFTRST 15
`define MSTF_B_ONESHOT 14
`define MSTF_F_MODE 2:0
`define MSTF_F_RATE 9:7
`define MSTF_F_CHEN 14:11
`define MSTF_B_AUX_RB 2
`define MSTF_B_AUX_OE 1
`define MSTF_B_AUX_VAL 0
`define MSTF_F_LIMV 15:11
`define MSTF_F_TEMP 10:7
`define MSTF_B_VRDY 6
`define MSTF_B_TRDY 5
`define MSTF_B_PVAL 4
`define MSTF_B_ALACT 3
`define MSTF_B_MOVF 2
`define MSTF_F_LOWZ 1:0
`define MSTF_F_MASK 15:4
`define MSTF_B_POL 1
`define MSTF_B_LATCH 0

// ==========================================================
// Rate codes and timing
`define MSTF_RATE_FAST 3'h7
`define MSTF_RATE_TWIN 3'h6
`define MSTF_FAST_MS 125
`define MSTF_MCLK_KHZ 40000
`define MSTF_ACK_SLOT 4'h8
`define MSTF_LAST_BIT 4'h7

`endif

// *** core/mstf_pkg.sv ***
// Purpose: Types shared by the monitor status-flag block
// Assumes: Constants come from mstf_defines.svh
// Notes:   Phase codes are one-hot
`include "mstf_defines.svh"

package mstf_pkg;

   // ==========================================================
   // Serial bus phases
   typedef enum logic [7:0] {
      PH_IDLE = 8'h01,
      PH_ADDR = 8'h02,
      PH_PTR = 8'h04,
      PH_WHI = 8'h08,
      PH_WLO = 8'h10,
      PH_RHI = 8'h20,
      PH_RLO = 8'h40,
      PH_SKIP = 8'h80
   } mstf_phase_e;

   // ==========================================================
   // Main clock domain state
   typedef struct packed {
      logic [15:0] cfg1;
      logic [15:0] cfg2;
      logic [15:0] alrt;
      logic [15:0] stat;
      mstf_phase_e phase;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic [7:0] dhi;
      logic [15:0] tx;
      logic ack_en;
      logic sda_oe;
      logic tog_q;
      logic scl_q;
      logic sda_q;
      logic [3:0] tdone;
      logic bo_seen;
      logic alert_act;
      logic [31:0] sub;
      logic [7:0] units;
      logic tstart;
      logic vtrig;
   } mstf_state_s;

   // Link clock domain state
   typedef struct packed {
      logic bitv;
      logic tog;
   } mstf_link_s;

endpackage

// *** core/mstf_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs are asynchronous to MCLK
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module mstf_sync #(
   parameter int W = 4
) (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } mstf_sync_s;

   mstf_sync_s s;
   mstf_sync_s next_s;

   always_comb
   begin
      next_s = s;
      next_s.s1 = D;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.out = ((s.s2 ~^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.out);
   end

   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
         s <= '0;
      else
         s <= next_s;
   end

   assign Q = s.out;

endmodule
`default_nettype wire

// *** core/mstf_top.sv ***
// Purpose: Status flags, conversion pacing, aux pin and serial register
//          access of a temperature and power monitor
// Assumes: Measurement results arrive as MCLK-synchronous levels/pulses
// Notes:   SCL clocks the link sampler; everything else runs on MCLK
// How it works
// RULE_01: Rate codes 0..7 give 1/16 up to 8 conversions per second.
// RULE_02: Code 110: 4/s for one or two channels, 8/3 three, 2 four.
// RULE_03: Code 111: 8/s one channel, 4/s two, 8/3 three.
// RULE_04: Trigger voltage conversion each period unless 111, none enabled, untriggered.
// RULE_05: Readback bit returns the live aux pin level.
// RULE_06: Aux pin mode 00/01 floats, 10 drives low, 11 drives high.
// RULE_07: Latch mode holds flags until status read; still violated sets again.
// RULE_08: Transparent mode clears a limit flag once no longer violated.
// RULE_09: Host reads status once after setup to discard power-up flags.
// RULE_10: Bits 15/14 flag shunt over positive and under negative limit.
// RULE_11: Bits 13/12 flag bus voltage over and under its limits.
// RULE_12: Bit 11 flags power above its limit.
// RULE_13: Bit 10 local temperature with hysteresis band for set and clear.
// RULE_14: Bits 9..7 remote temperatures with hysteresis, open diode also sets.
// RULE_15: Bit 6 voltage ready; cleared by one-shot write or status read.
// RULE_16: Bit 5 temperature ready after all enabled channels; same clears.
// RULE_17: Bit 4 brown-out in latch mode at conversion end; read clears.
// RULE_18: Bit 3 follows alert; latch clears by read, mask-off or response.
// RULE_19: Bit 2 math overflow; never drives the alert.
// RULE_20: Alert control bit 0 one selects latch, zero transparent.
// RULE_21: Status low two bits read zero; status writes ignored.
`timescale 1ns/1ps
`default_nettype none
`include "mstf_defines.svh"

module mstf_top
   import mstf_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h48,
   parameter int unsigned BASE_CYC = `MSTF_FAST_MS * `MSTF_MCLK_KHZ
) (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic AUX_PIN_IN,
   output logic AUX_PIN_OUT,
   output logic AUX_PIN_OE,
   output logic ALERT,
   input wire logic ALERT_RESP,
   input wire logic [4:0] LIMIT_VIOL,
   input wire logic [3:0] TEMP_ABOVE,
   input wire logic [3:0] TEMP_BELOW,
   input wire logic [2:0] OPEN_DIODE,
   input wire logic [3:0] TCHAN_END,
   input wire logic VCONV_END,
   input wire logic BROWN_OUT,
   input wire logic MATH_OVERFLOW,
   output logic TEMP_CONV_START,
   output logic VOLT_TRIGGER
);

   // ==========================================================
   // Link domain: sample SDA on SCL rise, toggle per bit
   mstf_link_s link_s;
   mstf_link_s next_link;

   always_comb
   begin
      next_link.bitv = SDA_IN;
      next_link.tog = ~link_s.tog;
   end

   always_ff @(posedge SCL or negedge NRST)
   begin
      if (!NRST)
         link_s <= '0;
      else
         link_s <= next_link;
   end

   // ==========================================================
   // Pin synchronisers
   logic [3:0] sy;

   mstf_sync #(.W(4)) u_sync (
      .MCLK(MCLK),
      .NRST(NRST),
      .D({link_s.tog, AUX_PIN_IN, SDA_IN, SCL}),
      .Q(sy)
   );

   // ==========================================================
   // Main state and decoded fields
   localparam mstf_state_s S_RST = '{
      cfg1: `MSTF_RST_CFG1, cfg2: `MSTF_RST_CFG2, alrt: `MSTF_RST_ALRT,
      stat: `MSTF_RST_STAT, phase: PH_IDLE, default: '0};

   mstf_state_s s;
   mstf_state_s next_s;
   logic [2:0] rate;
   logic [3:0] en;
   logic [2:0] nch;
   logic [7:0] pu;
   logic latch;
   logic trig_mode;
   logic rd_ph;
   logic busy;
   logic rise;
   logic fall;
   logic start_c;
   logic stop_c;
   logic rd_clr;
   logic wr_one;
   logic cond;
   logic [7:0] b;
   logic [7:0] txb;
   logic [15:0] wdata;
   logic [3:0] od;
   logic [3:0] tdn;

   assign rate = s.cfg2[`MSTF_F_RATE];
   assign en = s.cfg2[`MSTF_F_CHEN];
   assign nch = {2'h0, en[0]} + {2'h0, en[1]} + {2'h0, en[2]} +
      {2'h0, en[3]};
   assign latch = s.alrt[`MSTF_B_LATCH]; // RULE_20
   assign trig_mode = ~s.cfg1[2] & (|s.cfg1[1:0]);
   assign rd_ph = (s.phase == PH_RHI) || (s.phase == PH_RLO);
   assign busy = (s.phase != PH_IDLE) && (s.phase != PH_SKIP);
   assign rise = sy[3] != s.tog_q;
   assign fall = s.scl_q & ~sy[0];
   assign start_c = s.sda_q & ~sy[1] & sy[0];
   assign stop_c = ~s.sda_q & sy[1] & sy[0];
   assign b = {s.shift[6:0], link_s.bitv};
   assign txb = (s.phase == PH_RHI) ? s.tx[15:8] : s.tx[7:0];
   assign wdata = {s.dhi, b};
   assign od = {OPEN_DIODE, 1'b0};

   // Period in units of the fastest period
   always_comb
   begin
      if (rate == `MSTF_RATE_FAST)
         pu = {5'h00, nch}; // RULE_03
      else if (rate == `MSTF_RATE_TWIN)
         pu = (nch <= 3'h2) ? 8'h02 : {5'h00, nch}; // RULE_02
      else
         pu = 8'h80 >> rate; // RULE_01
   end

   // Register read view
   function automatic logic [15:0] rdata(input mstf_state_s st,
      input logic auxv);
      case (st.ptr)
         `MSTF_OFS_CFG1: rdata = st.cfg1;
         `MSTF_OFS_CFG2: rdata = {st.cfg2[15:3], auxv, st.cfg2[1:0]}; // RULE_05
         `MSTF_OFS_STAT: rdata = st.stat;
         `MSTF_OFS_ALRT: rdata = st.alrt;
         default: rdata = 16'h0000;
      endcase
   endfunction

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      next_s = s;
      rd_clr = 1'b0;
      wr_one = 1'b0;
      cond = 1'b0;
      tdn = '0;
      next_s.tstart = 1'b0;
      next_s.vtrig = 1'b0;
      next_s.tog_q = sy[3];
      next_s.scl_q = sy[0];
      next_s.sda_q = sy[1];

      // Serial bus protocol
      if (start_c)
      begin
         next_s.phase = PH_ADDR;
         next_s.cnt = '0;
         next_s.ack_en = 1'b0;
         next_s.sda_oe = 1'b0;
      end
      else if (stop_c)
      begin
         next_s.phase = PH_IDLE;
         next_s.sda_oe = 1'b0;
      end
      else
      begin
         if (rise && busy)
         begin
            if (s.cnt == `MSTF_ACK_SLOT)
            begin
               next_s.cnt = '0;
               if (rd_ph)
                  next_s.ack_en = 1'b0;
               if (rd_ph && !s.ack_en && link_s.bitv)
                  next_s.phase = PH_SKIP;
               // Host ack after a low byte reloads; a NACK ends the read
               if (s.phase == PH_RHI && !s.ack_en && !link_s.bitv)
               begin
                  next_s.tx = rdata(s, sy[2]);
                  rd_clr = (s.ptr == `MSTF_OFS_STAT);
               end
            end
            else
            begin
               next_s.cnt = s.cnt + 4'h1;
               next_s.shift = b;
               if (s.cnt == `MSTF_LAST_BIT)
               begin
                  case (s.phase)
                     PH_ADDR:
                     begin
                        if (b[7:1] == DEV_ADDR)
                        begin
                           next_s.ack_en = 1'b1;
                           next_s.phase = b[0] ? PH_RHI : PH_PTR;
                           if (b[0])
                           begin
                              next_s.tx = rdata(s, sy[2]);
                              rd_clr = (s.ptr == `MSTF_OFS_STAT);
                           end
                        end
                        else
                           next_s.phase = PH_SKIP;
                     end
                     PH_PTR:
                     begin
                        next_s.ptr = b;
                        next_s.phase = PH_WHI;
                     end
                     PH_WHI:
                     begin
                        next_s.dhi = b;
                        next_s.phase = PH_WLO;
                     end
                     PH_WLO:
                     begin
                        next_s.phase = PH_WHI;
                        case (s.ptr)
                           `MSTF_OFS_CFG1:
                           begin
                              next_s.cfg1 = wdata & `MSTF_CFG1_WMASK;
                              wr_one = wdata[`MSTF_B_ONESHOT];
                           end
                           `MSTF_OFS_CFG2:
                              next_s.cfg2 = wdata & `MSTF_CFG2_WMASK;
                           `MSTF_OFS_ALRT:
                              next_s.alrt = wdata;
                           default:
                              next_s.ptr = s.ptr; // RULE_21
                        endcase
                     end
                     PH_RHI:
                        next_s.phase = PH_RLO;
                     PH_RLO:
                        next_s.phase = PH_RHI;
                     default:
                        next_s.phase = PH_SKIP;
                  endcase
               end
            end
         end
         if (fall)
         begin
            if (s.cnt == `MSTF_ACK_SLOT)
               next_s.sda_oe = s.ack_en;
            else if (rd_ph && !s.ack_en)
               next_s.sda_oe = ~txb[3'(`MSTF_LAST_BIT - s.cnt)];
            else
               next_s.sda_oe = 1'b0;
         end
      end

      // Voltage limit flags
      for (int i = 0; i < 5; i++)
      begin
         if (latch)
            next_s.stat[11+i] = (s.stat[11+i] & ~rd_clr) |
               (VCONV_END & LIMIT_VIOL[i]); // RULE_07 RULE_10 RULE_11 RULE_12
         else if (VCONV_END)
            next_s.stat[11+i] = LIMIT_VIOL[i]; // RULE_08
      end

      // Temperature flags with hysteresis and open diode
      for (int k = 0; k < 4; k++)
      begin
         tdn[k] = TCHAN_END[k] & en[k];
         if (latch)
            next_s.stat[10-k] = (s.stat[10-k] & ~rd_clr) |
               (tdn[k] & (TEMP_ABOVE[k] | od[k])); // RULE_13 RULE_14
         else if (tdn[k] && (TEMP_ABOVE[k] || od[k]))
            next_s.stat[10-k] = 1'b1; // RULE_13 RULE_14
         else if (tdn[k] && TEMP_BELOW[k])
            next_s.stat[10-k] = 1'b0; // RULE_13 RULE_14
      end

      // Conversion ready flags
      next_s.stat[`MSTF_B_VRDY] = (s.stat[`MSTF_B_VRDY] & ~(rd_clr | wr_one))
         | VCONV_END; // RULE_15
      next_s.tdone = (s.tdone | tdn) & ~{4{wr_one}};
      next_s.stat[`MSTF_B_TRDY] = s.stat[`MSTF_B_TRDY] & ~(rd_clr | wr_one);
      if ((en != 4'h0) && ((next_s.tdone & en) == en))
      begin
         next_s.stat[`MSTF_B_TRDY] = 1'b1; // RULE_16
         next_s.tdone = '0;
      end

      // Brown-out seen during a voltage conversion
      next_s.bo_seen = (s.bo_seen | BROWN_OUT) & ~VCONV_END;
      next_s.stat[`MSTF_B_PVAL] = (s.stat[`MSTF_B_PVAL] & ~rd_clr) |
         (latch & VCONV_END & (s.bo_seen | BROWN_OUT)); // RULE_17

      // Math overflow, excluded from the alert mask range
      next_s.stat[`MSTF_B_MOVF] = (s.stat[`MSTF_B_MOVF] & ~rd_clr) |
         MATH_OVERFLOW; // RULE_19

      // Alert active
      // Latch mode alerts on newly set flags only
      cond = |(next_s.stat[`MSTF_F_MASK] & next_s.alrt[`MSTF_F_MASK] &
         (latch ? ~s.stat[`MSTF_F_MASK] : 12'hFFF));
      if (latch)
         next_s.alert_act = (s.alert_act & ~(rd_clr | ALERT_RESP |
            (next_s.alrt[`MSTF_F_MASK] == 12'h000))) | cond; // RULE_18
      else
         next_s.alert_act = cond; // RULE_18
      next_s.stat[`MSTF_B_ALACT] = next_s.alert_act;
      next_s.stat[`MSTF_F_LOWZ] = 2'h0; // RULE_21

      // Conversion pacing
      if (en == 4'h0)
      begin
         next_s.sub = '0;
         next_s.units = '0;
      end
      else if (s.sub >= 32'(BASE_CYC - 1))
      begin
         next_s.sub = '0;
         if ((s.units + 8'h01) >= pu)
         begin
            next_s.units = '0;
            next_s.tstart = 1'b1; // RULE_01
            next_s.vtrig = (rate != `MSTF_RATE_FAST) & trig_mode; // RULE_04
         end
         else
            next_s.units = s.units + 8'h01;
      end
      else
         next_s.sub = s.sub + 32'h0000_0001;

      // Soft reset through the configuration word
      if (rise && busy && s.phase == PH_WLO && s.cnt == `MSTF_LAST_BIT &&
         s.ptr == `MSTF_OFS_CFG1 && wdata[`MSTF_B_SOFTRST])
      begin
         next_s.cfg1 = `MSTF_RST_CFG1;
         next_s.cfg2 = `MSTF_RST_CFG2;
         next_s.alrt = `MSTF_RST_ALRT;
         next_s.stat = `MSTF_RST_STAT;
         next_s.alert_act = 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
         s <= S_RST;
      else
         s <= next_s;
   end

   // ==========================================================
   // Outputs
   assign SDA_OUT = 1'b0;
   assign SDA_OE = s.sda_oe;
   assign AUX_PIN_OE = s.cfg2[`MSTF_B_AUX_OE]; // RULE_06
   assign AUX_PIN_OUT = s.cfg2[`MSTF_B_AUX_VAL]; // RULE_06
   assign ALERT = s.alrt[`MSTF_B_POL] ? s.alert_act : ~s.alert_act;
   assign TEMP_CONV_START = s.tstart;
   assign VOLT_TRIGGER = s.vtrig;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!NRST);

   rate_period_a: assert property (next_s.tstart |-> // RULE_01
      (s.units + 8'h01) >= pu && s.sub >= 32'(BASE_CYC - 1))
      else $error("Conversion start before its period ended");
   rate_twin_a: assert property ((rate == `MSTF_RATE_TWIN && // RULE_02
      nch != 3'h0) |-> pu == ((nch <= 3'h2) ? 8'h02 : {5'h00, nch}))
      else $error("Rate code six period wrong");
   rate_fast_a: assert property ((rate == `MSTF_RATE_FAST && // RULE_03
      nch == 3'h1) |-> pu == 8'h01)
      else $error("Rate code seven period wrong");
   vtrig_gate_a: assert property (VOLT_TRIGGER |-> // RULE_04
      $past(rate) != `MSTF_RATE_FAST && $past(trig_mode) && TEMP_CONV_START)
      else $error("Voltage trigger outside its conditions");
   aux_drive_a: assert property (AUX_PIN_OE == // RULE_06
      (s.cfg2[1:0] == 2'h2 || s.cfg2[1:0] == 2'h3))
      else $error("Aux pin drive does not follow mode");
   read_clear_a: assert property ((rd_clr && latch && !VCONV_END && // RULE_07
      TCHAN_END == 4'h0) |=> s.stat[15:4] == 12'h000)
      else $error("Latched flags survived a status read");
   transp_volt_a: assert property ((!latch && VCONV_END) |=> // RULE_08
      s.stat[15:11] == $past(LIMIT_VIOL))
      else $error("Transparent voltage flags wrong");
   vready_a: assert property (VCONV_END |=> s.stat[6]) // RULE_15
      else $error("Voltage ready not set");
   pvalid_a: assert property ((latch && BROWN_OUT && VCONV_END) |=> // RULE_17
      s.stat[4])
      else $error("Power valid error not set");
   alert_trans_a: assert property (!$past(latch) |-> // RULE_18
      s.alert_act == |(s.stat[15:4] & s.alrt[15:4]))
      else $error("Transparent alert mismatch");
   low_zero_a: assert property (s.stat[1:0] == 2'h0) // RULE_21
      else $error("Status low bits not zero");

   logic rise_to_trdy;
   assign rise_to_trdy = !s.stat[5] && next_s.stat[5];

   read_status_c: cover property (rd_clr && latch);
   temp_ready_c: cover property (rise_to_trdy);
   alert_on_c: cover property (!s.alert_act ##1 s.alert_act);

endmodule
`default_nettype wire

// *** test/mstf_host_model.sv ***
// Purpose: Host controller model on the two-wire register bus
// Assumes: SDA has a pull-up and each party only pulls it low
// Notes:   SCL moves on a 48 ns grid and stands high between frames
`timescale 1ns/1ps
`default_nettype none

module mstf_host_model #(
   parameter logic [6:0] ADDR = 7'h48
) (
   output logic SCL,
   output logic SDA_IN,
   input wire logic SDA_OE
);
   // ==========================================================
   // Bit timing and wire level
   localparam int Q = 96;
   localparam int H = 240;
   logic pull_low = 1'b0;
   initial SCL = 1'b1;
   assign SDA_IN = ~(pull_low | SDA_OE);

   // ==========================================================
   // Frame pieces
   // Data moves 96 ns after SCL falls so it never looks like a start
   task automatic start_bit();
      #(H + 5) pull_low = 1'b1;
      #(H) SCL = 1'b0;
   endtask
   task automatic stop_bit();
      #(Q) pull_low = 1'b1;
      #(H - Q) SCL = 1'b1;
      #(H) pull_low = 1'b0;
      #(H);
   endtask
   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         #(Q) pull_low = ~b[i];
         #(H - Q) SCL = 1'b1;
         #(H) SCL = 1'b0;
      end
      #(Q) pull_low = 1'b0;
      #(H - Q) SCL = 1'b1;
      #(H) SCL = 1'b0;
   endtask
   task automatic get_byte(output logic [7:0] b, input logic last);
      for (int i = 7; i >= 0; i--)
      begin
         #(Q) pull_low = 1'b0;
         #(H - Q) SCL = 1'b1;
         b[i] = SDA_IN;
         #(H) SCL = 1'b0;
      end
      #(Q) pull_low = ~last;
      #(H - Q) SCL = 1'b1;
      #(H) SCL = 1'b0;
   endtask

   // ==========================================================
   // Register access
   task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d,
                            input logic full);
      start_bit();
      put_byte({ADDR, 1'b0});
      put_byte(ptr);
      if (full)
      begin
         put_byte(d[15:8]);
         put_byte(d[7:0]);
      end
      stop_bit();
   endtask
   task automatic read_reg(input logic [7:0] ptr, output logic [15:0] d);
      write_reg(ptr, 16'h0000, 1'b0);
      start_bit();
      put_byte({ADDR, 1'b1});
      get_byte(d[15:8], 1'b0);
      get_byte(d[7:0], 1'b1);
      stop_bit();
   endtask
endmodule
`default_nettype wire

// *** test/test_mstf_top.sv ***
// Purpose: Self-checking bench of the monitor status-flag block
// Assumes: Conversion period base shortened to 20 MCLK cycles
// Notes:   Register traffic comes from the host model
`timescale 1ns/1ps
`default_nettype none

module test_mstf_top;
   // ==========================================================
   // Design and host
   localparam int BASE = 20;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic scl, sda_in, sda_oe, aux_in, aux_out, aux_oe, alert, tstart, vtrig;
   logic aux_ext = 1'b1;
   logic alert_resp = 1'b0;
   logic vconv_end = 1'b0;
   logic brown_out = 1'b0;
   logic math_ovf = 1'b0;
   logic [4:0] limit_viol = 5'h00;
   logic [3:0] t_above = 4'h0;
   logic [3:0] t_below = 4'h0;
   logic [3:0] tch_end = 4'h0;
   logic [2:0] open_diode = 3'h0;
   logic [15:0] rd;
   int err_count = 0;
   int comparisons = 0;
   always #12.5 mclk = ~mclk;
   assign aux_in = aux_oe ? aux_out : aux_ext;
   mstf_top #(.DEV_ADDR(7'h48), .BASE_CYC(BASE)) uut (
      .MCLK(mclk), .NRST(nrst), .SCL(scl), .SDA_IN(sda_in), .SDA_OUT(),
      .SDA_OE(sda_oe), .AUX_PIN_IN(aux_in), .AUX_PIN_OUT(aux_out),
      .AUX_PIN_OE(aux_oe), .ALERT(alert), .ALERT_RESP(alert_resp),
      .LIMIT_VIOL(limit_viol), .TEMP_ABOVE(t_above), .TEMP_BELOW(t_below),
      .OPEN_DIODE(open_diode), .TCHAN_END(tch_end), .VCONV_END(vconv_end),
      .BROWN_OUT(brown_out), .MATH_OVERFLOW(math_ovf),
      .TEMP_CONV_START(tstart), .VOLT_TRIGGER(vtrig));
   mstf_host_model #(.ADDR(7'h48)) host (.SCL(scl), .SDA_IN(sda_in),
      .SDA_OE(sda_oe));

   // ==========================================================
   // Checks and stimulus tasks
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp,
                          input logic got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic rdchk(input logic [7:0] ptr, input logic [15:0] exp,
                        input string what);
      host.read_reg(ptr, rd);
      chk(what, exp, rd);
   endtask
   task automatic vconv(input logic [4:0] v, input logic bo,
                        input logic ov);
      @(posedge mclk);
      limit_viol <= v;
      brown_out <= bo;
      math_ovf <= ov;
      @(posedge mclk);
      vconv_end <= 1'b1;
      math_ovf <= 1'b0;
      @(posedge mclk);
      vconv_end <= 1'b0;
      brown_out <= 1'b0;
      limit_viol <= 5'h00;
      repeat (4) @(posedge mclk);
   endtask
   task automatic tchan(input logic [3:0] a, input logic [3:0] b,
                        input logic [2:0] od);
      @(posedge mclk);
      t_above <= a;
      t_below <= b;
      open_diode <= od;
      @(posedge mclk);
      tch_end <= 4'hF;
      @(posedge mclk);
      tch_end <= 4'h0;
      repeat (3) @(posedge mclk);
   endtask
   // Counts edges up to the next start pulse, bounded
   task automatic next_start(output logic [15:0] n);
      n = 16'h0000;
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (tstart !== 1'b1 && n < 16'h1800);
   endtask
   task automatic pace(input logic [2:0] code, input logic [3:0] chen,
                       input logic [15:0] units, input logic vt);
      logic [15:0] n;
      host.write_reg(8'h01, {1'b1, chen, 1'b1, code, 7'h00}, 1'b1);
      next_start(n);
      next_start(n);
      chk("period", units * 16'(BASE), n);
      chk_bit("volt trigger", vt, vtrig);
   endtask
   task automatic done(input string name);
      $display("test %s done", name);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial
   begin
      logic exp_b;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      repeat (8) @(posedge mclk);
      rdchk(8'h00, 16'h399F, "cfg1");
      rdchk(8'h01, 16'hFF84, "cfg2");
      rdchk(8'h03, 16'h0000, "alert reg");
      rdchk(8'h02, 16'h0000, "status");
      rdchk(8'h07, 16'h0000, "unmapped");
      done("reset");
      for (int m = 0; m < 4; m++)
      begin
         exp_b = m[1] ? m[0] : ~m[0];
         aux_ext <= ~m[0];
         host.write_reg(8'h01, 16'hFF80 | 16'(m), 1'b1);
         chk_bit("aux oe", m[1], aux_oe);
         chk_bit("aux pin", exp_b, aux_in);
         rdchk(8'h01, 16'hFF80 | 16'(m) | 16'(exp_b) << 2, "cfg2");
      end
      host.write_reg(8'h01, 16'hFF80, 1'b1);
      done("aux pin");
      host.write_reg(8'h03, 16'hFF81, 1'b1);
      vconv(5'h00, 1'b0, 1'b1);
      chk_bit("alert pin", 1'b1, alert);
      rdchk(8'h02, 16'h0044, "status");
      vconv(5'h1F, 1'b1, 1'b0);
      chk_bit("alert pin", 1'b0, alert);
      rdchk(8'h02, 16'hF858, "status");
      chk_bit("alert pin", 1'b1, alert);
      rdchk(8'h02, 16'h0000, "status");
      vconv(5'h1F, 1'b0, 1'b0);
      @(posedge mclk);
      alert_resp <= 1'b1;
      @(posedge mclk);
      alert_resp <= 1'b0;
      repeat (3) @(posedge mclk);
      chk_bit("alert pin", 1'b1, alert);
      host.read_reg(8'h02, rd);
      chk("status", 16'hF840, rd & 16'hFFF7);
      done("latch");
      host.write_reg(8'h03, 16'h8002, 1'b1);
      chk_bit("alert pin", 1'b0, alert);
      vconv(5'h10, 1'b0, 1'b0);
      chk_bit("alert pin", 1'b1, alert);
      rdchk(8'h02, 16'h8048, "status");
      vconv(5'h00, 1'b0, 1'b0);
      chk_bit("alert pin", 1'b0, alert);
      rdchk(8'h02, 16'h0040, "status");
      tchan(4'h1, 4'h0, 3'h1);
      rdchk(8'h02, 16'h0620, "status");
      tchan(4'h0, 4'h0, 3'h0);
      rdchk(8'h02, 16'h0620, "status");
      tchan(4'h0, 4'hF, 3'h0);
      vconv(5'h00, 1'b0, 1'b0);
      host.write_reg(8'h00, 16'h799F, 1'b1);
      host.write_reg(8'h02, 16'hFFFF, 1'b1);
      rdchk(8'h02, 16'h0000, "status");
      done("transparent");
      host.write_reg(8'h00, 16'h399B, 1'b1);
      for (int c = 0; c < 6; c++)
         pace(3'(c), 4'hF, 16'h0080 >> c, 1'b1);
      pace(3'h6, 4'h3, 16'h0002, 1'b1);
      pace(3'h6, 4'h7, 16'h0003, 1'b1);
      pace(3'h6, 4'hF, 16'h0004, 1'b1);
      pace(3'h7, 4'h1, 16'h0001, 1'b0);
      pace(3'h7, 4'h3, 16'h0002, 1'b0);
      pace(3'h7, 4'h7, 16'h0003, 1'b0);
      host.write_reg(8'h00, 16'h399F, 1'b1);
      pace(3'h5, 4'hF, 16'h0004, 1'b0);
      done("pacing");
      report_and_stop();
   end

   initial
   begin
      repeat (100000) @(posedge mclk);
      err_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
